// >>> pkg/hbsp_pkg.sv
`default_nettype none
package hbsp_pkg;
	localparam int WordBits = 16;
	localparam int NumBridges = 10;
	localparam int LowerCount = 6;
	localparam int UpperCount = 4;
	localparam int UpperBase = 6;
	localparam int FaultBits = 3 + 2 * NumBridges;
	// command word fields
	localparam int SrrBit = 15;
	localparam int GroupSelBit = 14;
	localparam int UldEnBit = 13;
	localparam int EnBase = 7;
	localparam int SideBase = 1;
	localparam int OvloBit = 0;
	// status word fields
	localparam int StOcBit = 15;
	localparam int StSupplyBit = 14;
	localparam int StUldBit = 13;
	localparam int StTwBit = 0;
	localparam logic [15:0] CmdReset = 16'h0000;
	localparam logic [15:0] StatusReset = 16'h0000;
	// frame length check
	localparam int CntWidth = 4;
	localparam logic [3:0] CntLast = 4'hF;
	localparam logic [3:0] CntZero = 4'h0;
	localparam logic [3:0] CntOne = 4'h1;
	localparam logic [3:0] TopIdx = 4'hF;
	localparam int ModLowBits = 3;
	localparam logic [2:0] ModZero = 3'h0;
	// power-up time after enable
	localparam int ClkPeriodNs = 50;
	localparam int PorTimeUs = 100;
	localparam int PorCycles = (PorTimeUs * 1000) / ClkPeriodNs;
	localparam int PorCntWidth = 12;
	localparam logic [11:0] PorLast = 12'(PorCycles - 1);
	localparam logic [11:0] PorZero = 12'h000;
	localparam logic [11:0] PorOne = 12'h001;
	// command spacing the master keeps
	localparam real CsHighTimeUs = 5.0;
	localparam int SrrSpacingUs = 150;
	typedef enum logic [1:0] {
		SLEEP,
		POWERUP,
		ACTIVE
	} hbsp_state_type;
endpackage : hbsp_pkg
`default_nettype wire

// >>> logic/hbsp_port.sv
// Summary of operation
// - enable low clears command, fault latch and status registers, resets drivers, enters sleep.
// - enable high runs power-up delay, then accepts serial writes.
// - serial port works only while enable is high and ready.
// - full duplex 16-bit frames, command in while status out.
// - chip select falling drives thermal pre-bit until first rising clock.
// - serial data sampled on falling serial clock edge.
// - status shifted out on rising edges, MSB first, overcurrent first.
// - deselect ends frame and floats serial output.
// - good frame loads last 16 bits; bad frame discarded whole.
// - bit 15 clears latched faults of selected group if gone.
// - bit 14 set: upper group enables, sides, underload, lockout.
// - bit 14 clear: lower group enables, sides, underload, lockout.
// - command bits cleared to zero at power-up reset.
// - frame valid if 16 clocks then multiples of eight.
`default_nettype none
module hbsp_port (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic globalEnable,
	input wire logic chipSelectN,
	input wire logic serialClock,
	input wire logic serialIn,
	output logic serialOutO,
	output logic serialOutOe,
	input wire logic thermalShutdownFault,
	input wire logic thermalWarning,
	input wire logic supplyFault,
	input wire logic [hbsp_pkg::NumBridges-1:0] overcurrentFault,
	input wire logic [hbsp_pkg::NumBridges-1:0] underloadFault,
	output logic [hbsp_pkg::NumBridges-1:0] bridgeOutputEnable,
	output logic [hbsp_pkg::NumBridges-1:0] bridgeSideConfig,
	output logic overvoltageLockoutEnable,
	output logic sleepMode,
	output logic portReady
);
	import hbsp_pkg::*;

	// link side: receive on falling edges
	logic [WordBits-1:0] rxShift_q;
	logic [CntWidth-1:0] fallCnt_q;
	logic seen16_q;
	logic frameOk;
	// link side: transmit on rising edges
	logic [CntWidth-1:0] riseCnt_q;
	logic started_q;
	logic past16_q;
	logic txBit_q;
	// captured at deselect
	logic [WordBits-1:0] frameWord_q;
	logic frameOk_q;
	// system side
	logic enMeta_q;
	logic enSync_q;
	logic csMeta_q;
	logic csSync_q;
	logic csSyncD_q;
	logic [FaultBits-1:0] faultMeta_q;
	logic [FaultBits-1:0] faultSync_q;
	logic tsdIn;
	logic twIn;
	logic supplyIn;
	logic [NumBridges-1:0] ocIn;
	logic [NumBridges-1:0] uldIn;
	hbsp_state_type state_q;
	logic [PorCntWidth-1:0] porCnt_q;
	logic frameDone;
	logic accept;
	logic srrReq;
	logic srrUpper;
	logic [WordBits-1:0] upperCmd_q;
	logic [WordBits-1:0] lowerCmd_q;
	logic groupSel_q;
	logic overvoltage_lockout_enable_q;
	logic tsdLatch_q;
	logic [NumBridges-1:0] ocLatch_q;
	logic [NumBridges-1:0] uldLatch_q;
	logic [NumBridges-1:0] outEn_q;
	logic [NumBridges-1:0] outSide_q;
	logic [WordBits-1:0] statusNow;
	logic [WordBits-1:0] statusHold_q;
	logic preBitHold_q;
	logic sleep_q;

	// ---- serial clock domain ----
	// counters restart while deselected; sclk may stand still outside frames
	always_ff @(negedge serialClock or posedge chipSelectN) begin
		if (chipSelectN) begin
			fallCnt_q <= CntZero;
			seen16_q <= 1'b0;
		end else begin
			fallCnt_q <= fallCnt_q + CntOne;
			if (fallCnt_q == CntLast) begin
				seen16_q <= 1'b1;
			end
		end
	end

	always_ff @(negedge serialClock) begin
		if (!chipSelectN) begin
			rxShift_q <= {rxShift_q[WordBits-2:0], serialIn};
		end
	end

	// 16 first, then any multiple of eight for daisy chains
	assign frameOk = seen16_q && (fallCnt_q[ModLowBits-1:0] == ModZero);

	always_ff @(posedge serialClock or posedge chipSelectN) begin
		if (chipSelectN) begin
			riseCnt_q <= CntZero;
			started_q <= 1'b0;
			past16_q <= 1'b0;
			txBit_q <= 1'b0;
		end else begin
			started_q <= 1'b1;
			riseCnt_q <= riseCnt_q + CntOne;
			if (riseCnt_q == CntLast) begin
				past16_q <= 1'b1;
			end
			// beyond 16 clocks the received word passes through
			if (past16_q) begin
				txBit_q <= rxShift_q[WordBits-1];
			end else begin
				txBit_q <= statusHold_q[TopIdx - riseCnt_q];
			end
		end
	end

	// frame result is taken at the deselect edge itself
	always_ff @(posedge chipSelectN) begin
		frameWord_q <= rxShift_q;
		frameOk_q <= frameOk;
	end

	assign serialOutO = started_q ? txBit_q : preBitHold_q;
	assign serialOutOe = !chipSelectN && portReady;

	// ---- system clock domain ----
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			enMeta_q <= 1'b0;
			enSync_q <= 1'b0;
		end else begin
			enMeta_q <= globalEnable;
			enSync_q <= enMeta_q;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			csMeta_q <= 1'b1;
			csSync_q <= 1'b1;
			csSyncD_q <= 1'b1;
		end else begin
			csMeta_q <= chipSelectN;
			csSync_q <= csMeta_q;
			csSyncD_q <= csSync_q;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			faultMeta_q <= '0;
			faultSync_q <= '0;
		end else begin
			faultMeta_q <= {thermalShutdownFault, thermalWarning, supplyFault, overcurrentFault, underloadFault};
			faultSync_q <= faultMeta_q;
		end
	end

	assign {tsdIn, twIn, supplyIn, ocIn, uldIn} = faultSync_q;

	// power state
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state_q <= SLEEP;
			porCnt_q <= PorZero;
		end else begin
			case (state_q)
				SLEEP: begin
					porCnt_q <= PorZero;
					if (enSync_q) begin
						state_q <= POWERUP;
					end
				end
				POWERUP: begin
					porCnt_q <= porCnt_q + PorOne;
					if (!enSync_q) begin
						state_q <= SLEEP;
					end else if (porCnt_q == PorLast) begin
						state_q <= ACTIVE;
					end
				end
				ACTIVE: begin
					if (!enSync_q) begin
						state_q <= SLEEP;
					end
				end
				default: begin
					state_q <= SLEEP;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			sleep_q <= 1'b1;
		end else begin
			sleep_q <= (state_q == SLEEP) || !enSync_q;
		end
	end

	assign sleepMode = sleep_q;
	assign portReady = (state_q == ACTIVE);

	// master keeps select high long enough for two mclk samples
	assign frameDone = csSync_q && !csSyncD_q;
	assign accept = frameDone && frameOk_q && (state_q == ACTIVE) && enSync_q;
	assign srrReq = accept && frameWord_q[SrrBit];
	assign srrUpper = frameWord_q[GroupSelBit];

	always_ff @(posedge mclk) begin
		if (!nrst || !enSync_q) begin
			upperCmd_q <= CmdReset;
			lowerCmd_q <= CmdReset;
			groupSel_q <= 1'b0;
			overvoltage_lockout_enable_q <= 1'b0;
		end else if (accept) begin
			groupSel_q <= frameWord_q[GroupSelBit];
			overvoltage_lockout_enable_q <= frameWord_q[OvloBit];
			if (frameWord_q[GroupSelBit]) begin
				upperCmd_q <= frameWord_q;
			end else begin
				lowerCmd_q <= frameWord_q;
			end
		end
	end

	// thermal shutdown is global; a fresh fault beats the clear
	always_ff @(posedge mclk) begin
		if (!nrst || !enSync_q) begin
			tsdLatch_q <= 1'b0;
		end else if (tsdIn) begin
			tsdLatch_q <= 1'b1;
		end else if (srrReq) begin
			tsdLatch_q <= 1'b0;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NumBridges; gi++) begin : gBridge
			localparam bit IsUpper = (gi >= UpperBase);
			localparam int Pos = IsUpper ? gi - UpperBase : gi;
			logic enBit;
			logic sideBit;
			logic uldShut;
			logic live;

			assign enBit = IsUpper ? upperCmd_q[EnBase + Pos] : lowerCmd_q[EnBase + Pos];
			assign sideBit = IsUpper ? upperCmd_q[SideBase + Pos] : lowerCmd_q[SideBase + Pos];
			assign uldShut = IsUpper ? upperCmd_q[UldEnBit] : lowerCmd_q[UldEnBit];
			assign live = enBit && !ocLatch_q[gi] && !(uldShut && uldLatch_q[gi]) && !tsdLatch_q
				&& !(overvoltage_lockout_enable_q && supplyIn);

			// latched faults clear only when gone
			always_ff @(posedge mclk) begin
				if (!nrst || !enSync_q) begin
					ocLatch_q[gi] <= 1'b0;
					uldLatch_q[gi] <= 1'b0;
				end else begin
					if (ocIn[gi]) begin
						ocLatch_q[gi] <= 1'b1;
					end else if (srrReq && (srrUpper == IsUpper)) begin
						ocLatch_q[gi] <= 1'b0;
					end
					if (uldIn[gi] && enBit) begin
						uldLatch_q[gi] <= 1'b1;
					end else if (srrReq && (srrUpper == IsUpper)) begin
						uldLatch_q[gi] <= 1'b0;
					end
				end
			end

			// side is forced low while the bridge floats
			always_ff @(posedge mclk) begin
				if (!nrst || !enSync_q) begin
					outEn_q[gi] <= 1'b0;
					outSide_q[gi] <= 1'b0;
				end else begin
					outEn_q[gi] <= live;
					outSide_q[gi] <= live && sideBit;
				end
			end
		end
	endgenerate

	assign bridgeOutputEnable = outEn_q;
	assign bridgeSideConfig = outSide_q;
	assign overvoltageLockoutEnable = overvoltage_lockout_enable_q;

	// status for the group of the last accepted command
	always_comb begin
		statusNow = StatusReset;
		statusNow[StSupplyBit] = supplyIn;
		statusNow[StTwBit] = twIn;
		if (groupSel_q) begin
			statusNow[StOcBit] = |ocLatch_q[UpperBase +: UpperCount];
			statusNow[StUldBit] = |uldLatch_q[UpperBase +: UpperCount];
			statusNow[EnBase +: UpperCount] = outEn_q[UpperBase +: UpperCount];
			statusNow[SideBase +: UpperCount] = outSide_q[UpperBase +: UpperCount];
		end else begin
			statusNow[StOcBit] = |ocLatch_q[LowerCount-1:0];
			statusNow[StUldBit] = |uldLatch_q[LowerCount-1:0];
			statusNow[EnBase +: LowerCount] = outEn_q[LowerCount-1:0];
			statusNow[SideBase +: LowerCount] = outSide_q[LowerCount-1:0];
		end
	end

	// frozen while selected so the link reads a steady word;
	// a fault within the sync delay of select shows next frame
	always_ff @(posedge mclk) begin
		if (!nrst || !enSync_q) begin
			statusHold_q <= StatusReset;
			preBitHold_q <= 1'b0;
		end else if (csSync_q) begin
			statusHold_q <= statusNow;
			preBitHold_q <= tsdLatch_q;
		end
	end

endmodule : hbsp_port
`default_nettype wire

// >>> testbench/hbsp_port_chk.sv
`default_nettype none
module hbsp_port_chk (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic globalEnable,
	input wire logic chipSelectN,
	input wire logic serialOutOe,
	input wire logic [hbsp_pkg::NumBridges-1:0] bridgeOutputEnable,
	input wire logic [hbsp_pkg::NumBridges-1:0] bridgeSideConfig,
	input wire logic overvoltageLockoutEnable,
	input wire logic sleepMode,
	input wire logic portReady
);
	import hbsp_pkg::*;
	// saturates so a long awake spell never wraps back under the bound
	logic [11:0] awakeCnt_q;
	always_ff @(posedge mclk) begin
		if (!nrst || sleepMode) begin
			awakeCnt_q <= 12'h000;
		end else if (awakeCnt_q != 12'hFFF) begin
			awakeCnt_q <= awakeCnt_q + 12'h001;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	chk_float_deselect: assert property (chipSelectN |-> !serialOutOe)
		else $error("output driven while deselected");
	chk_quiet_unready: assert property (!portReady |-> !serialOutOe)
		else $error("output driven while not ready");
	chk_prebit_drive: assert property ($fell(chipSelectN) && portReady |-> serialOutOe)
		else $error("pre-bit not driven at select");
	chk_sleep_entry: assert property ($fell(globalEnable) |-> ##[1:4] sleepMode)
		else $error("no sleep after enable low");
	chk_sleep_clears: assert property (sleepMode[*2] |-> bridgeOutputEnable == 10'h000 && !overvoltageLockoutEnable)
		else $error("outputs kept in sleep");
	chk_ready_delay: assert property ($rose(portReady) |-> awakeCnt_q >= 12'h7CB)
		else $error("ready before power-up delay");
	chk_idle_hold: assert property ((chipSelectN && globalEnable)[*6] |=> $stable(overvoltageLockoutEnable))
		else $error("command changed while deselected");
	chk_side_gated: assert property ((bridgeSideConfig & ~bridgeOutputEnable) == 10'h000)
		else $error("side set on disabled bridge");
	chk_ready_gone: assert property (!globalEnable[*4] |-> !portReady)
		else $error("ready while enable low");
	cov_ready: cover property ($rose(portReady));
	cov_frame: cover property ($rose(chipSelectN) && portReady);
	cov_sleep: cover property ($rose(sleepMode));
endmodule : hbsp_port_chk
bind hbsp_port hbsp_port_chk i_hbsp_port_chk (.mclk(mclk), .nrst(nrst), .globalEnable(globalEnable),
	.chipSelectN(chipSelectN), .serialOutOe(serialOutOe), .bridgeOutputEnable(bridgeOutputEnable),
	.bridgeSideConfig(bridgeSideConfig), .overvoltageLockoutEnable(overvoltageLockoutEnable),
	.sleepMode(sleepMode), .portReady(portReady));
`default_nettype wire

// >>> testbench/hbsp_master.sv
`default_nettype none
module hbsp_master (
	output logic chipSelectN,
	output logic serialClock,
	output logic serialIn,
	input wire logic serialOutO,
	input wire logic serialOutOe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic soLine;
	// a floating line reads back inverted, so a missing enable shows up
	assign soLine = serialOutOe ? serialOutO : !serialOutO;
	initial begin
		chipSelectN = 1'b1;
		serialClock = 1'b0;
		serialIn = 1'b0;
	end
	// link clock 64 ns, only inside frames; bits above 15 are daisy filler
	task automatic frame(input logic [15:0] w, input int n, output logic pre, output logic oe,
		output logic [15:0] rx);
		rx = 16'h0000;
		#13;
		chipSelectN = 1'b0;
		#100;
		pre = soLine;
		oe = serialOutOe;
		for (int i = n - 1; i >= 0; i--) begin
			serialClock = 1'b1;
			serialIn = (i < 16) ? w[i[3:0]] : 1'b1;
			#20;
			rx = {rx[14:0], soLine};
			#12;
			serialClock = 1'b0;
			#32;
		end
		serialIn = 1'b0;
		#32;
		chipSelectN = 1'b1;
		#5000;
	endtask : frame
	// clock and data wiggle with select high, lines parked low afterwards
	task automatic idle_clocks(input int n);
		for (int i = 0; i < n; i++) begin
			serialIn = 1'b1;
			serialClock = 1'b1;
			#32;
			serialClock = 1'b0;
			#32;
		end
		serialIn = 1'b0;
		#200;
	endtask : idle_clocks
endmodule : hbsp_master
`default_nettype wire

// >>> testbench/hbsp_port_bench.sv
`default_nettype none
module hbsp_port_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, nrst, globalEnable, tsd, tw, csN, sclk, si, soO, soOe, overvoltage_lockout_enable, sleep, ready, pre, oe;
	logic [9:0] bEn, bSide, oc;
	logic [9:0] faultZero = 10'h000;
	logic [15:0] rx;
	int err_total = 0;
	int cmp_count = 0;
	int cycles = 0;
	hbsp_port i_hbsp_port (.mclk(mclk), .nrst(nrst), .globalEnable(globalEnable), .chipSelectN(csN),
		.serialClock(sclk), .serialIn(si), .serialOutO(soO), .serialOutOe(soOe), .thermalShutdownFault(tsd),
		.thermalWarning(tw), .supplyFault(1'b0), .overcurrentFault(oc), .underloadFault(faultZero),
		.bridgeOutputEnable(bEn), .bridgeSideConfig(bSide), .overvoltageLockoutEnable(overvoltage_lockout_enable),
		.sleepMode(sleep), .portReady(ready));
	hbsp_master i_hbsp_master (.chipSelectN(csN), .serialClock(sclk), .serialIn(si), .serialOutO(soO),
		.serialOutOe(soOe));
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		cmp_count++;
		if (seen !== want) begin
			err_total++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check
	task automatic give_verdict();
		$display("errors %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : give_verdict
	task automatic t_powerup();
		int n;
		n = 0;
		check(16'(sleep), 16'h0001);
		i_hbsp_master.frame(16'h1F80, 16, pre, oe, rx);
		check({oe, bEn, 4'h0, overvoltage_lockout_enable}, 16'h0000);
		@(posedge mclk);
		globalEnable <= 1'b1;
		// sampled half a cycle away from the edge that launches it
		while (ready !== 1'b1 && n < 2500) begin
			@(negedge mclk);
			n++;
		end
		check(16'(n >= 1995 && n <= 2010), 16'h0001);
		check({bEn, bSide[5:0]}, 16'h0000);
	endtask : t_powerup
	task automatic t_groups();
		i_hbsp_master.frame(16'h1FD5, 16, pre, oe, rx);
		check({bSide[5:0], bEn[5:0], 3'h0, overvoltage_lockout_enable}, 16'hABF1);
		// unused bits 12, 11, 6, 5 set on purpose
		i_hbsp_master.frame(16'h5FEA, 16, pre, oe, rx);
		check({bSide[9:6], bEn[9:6], bSide[5:0], 1'b0, overvoltage_lockout_enable}, 16'h5FA8);
	endtask : t_groups
	task automatic t_framing();
		// a stray clock with select high must neither shift nor count
		i_hbsp_master.idle_clocks(1);
		check({bSide[9:6], bEn[9:6], bSide[5:0], 1'b0, overvoltage_lockout_enable}, 16'h5FA8);
		i_hbsp_master.frame(16'h0000, 15, pre, oe, rx);
		check(rx, 16'h03C5);
		check({14'h0000, oe, pre}, 16'h0002);
		i_hbsp_master.frame(16'h0000, 17, pre, oe, rx);
		check({bEn, 5'h00, overvoltage_lockout_enable}, 16'hFFC0);
		i_hbsp_master.frame(16'h0000, 16, pre, oe, rx);
		check(rx, 16'h078A);
		i_hbsp_master.frame(16'h0001, 24, pre, oe, rx);
		check({bEn, 5'h00, overvoltage_lockout_enable}, 16'hF001);
		// low status byte, then the first received byte passed through
		check(rx, 16'h00FF);
	endtask : t_framing
	task automatic t_thermal();
		@(posedge mclk);
		tsd <= 1'b1;
		repeat (10) @(posedge mclk);
		tsd <= 1'b0;
		repeat (10) @(posedge mclk);
		i_hbsp_master.frame(16'h8000, 16, pre, oe, rx);
		check(16'(pre), 16'h0001);
		#150000;
		i_hbsp_master.frame(16'h0000, 16, pre, oe, rx);
		check(16'(pre), 16'h0000);
	endtask : t_thermal
	task automatic t_overcurrent();
		@(posedge mclk);
		oc <= 10'h040;
		tw <= 1'b1;
		repeat (10) @(posedge mclk);
		oc <= 10'h000;
		repeat (10) @(posedge mclk);
		check({6'h00, bEn}, 16'h0380);
		// first frame only steers the status to the upper group
		i_hbsp_master.frame(16'h5FEA, 16, pre, oe, rx);
		i_hbsp_master.frame(16'hDFEA, 16, pre, oe, rx);
		check(rx, 16'h8709);
		check({bSide[9:6], bEn[9:6], 8'h00}, 16'h5F00);
		@(posedge mclk);
		tw <= 1'b0;
	endtask : t_overcurrent
	task automatic t_disable();
		@(posedge mclk);
		globalEnable <= 1'b0;
		repeat (5) @(posedge mclk);
		check({bEn, bSide[4:0], sleep}, 16'h0001);
		i_hbsp_master.frame(16'h1F80, 16, pre, oe, rx);
		check({4'h0, oe, bEn, overvoltage_lockout_enable}, 16'h0000);
	endtask : t_disable
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// ceiling well above the roughly 7000 cycles the run needs
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total++;
			give_verdict();
		end
	end
	initial begin
		nrst = 1'b0;
		globalEnable = 1'b0;
		tsd = 1'b0;
		tw = 1'b0;
		oc = 10'h000;
		repeat (8) @(posedge mclk);
		nrst <= 1'b1;
		repeat (2) @(posedge mclk);
		t_powerup();
		t_groups();
		t_framing();
		t_thermal();
		t_overcurrent();
		t_disable();
		give_verdict();
	end
endmodule : hbsp_port_bench
`default_nettype wire
